//--- rtl/sysref_capture_windowing.v
/*
 * SYSREF capture and windowing: builds the phase map from delayed taps,
 * captures SYSREF at the software-picked tap, resets the LMFC/LEMC counter.
 * Assumes sysref_taps_in come from an external delay line whose step is set
 * by fine_step_out, already registered on ref_clk_in.
 */
// What this block does
// RULE_01: Detect SYSREF timing against clock edge; capture at selectable delayed tap.
// RULE_02: Capture happens on a deterministic device clock edge every power-on.
// RULE_03: Record measured SYSREF location in phase map, one bit per position.
// RULE_04: Bit 1 means setup/hold risk, bit 0 means valid choice.
// RULE_05: Phase map bits 0 and 23 always read as 1.
// RULE_06: Sample pick holds decimal index of chosen bit; capture uses it.
// RULE_07: Map reports 24 positions; pick selects only positions 0 to 15.
// RULE_08: Positions above 15 are information only, never capture points.
// RULE_09: Fine step control 0 gives coarse steps, 1 gives fine steps.
// RULE_10: Software uses fine steps unless no run of ones appears.
// RULE_11: Software picks midway between violation regions, favouring low indices.
// RULE_12: Software may store the best pick once and reload every power-up.
// RULE_13: Periodic SYSREF frequency must match the multiframe or multiblock rate.
// RULE_14: Captured SYSREF resets the LMFC or LEMC counter deterministically.
// RULE_15: Sample pick field is four bits, binary index of position.
`timescale 1ns/10ps
`default_nettype none
`include "sysref_window_map.vh"

module sysref_capture_windowing #(
  parameter MAP_POSITIONS  = `MAP_POSITIONS,
  parameter PICK_POSITIONS = `PICK_POSITIONS,
  parameter PICK_WIDTH     = `PICK_WIDTH,
  parameter CNT_WIDTH      = 8
) (
  // Clock and reset
  input  wire                     ref_clk_in,
  input  wire                     rst_n_in,
  // Delayed SYSREF samples, tap 0 smallest delay
  input  wire [MAP_POSITIONS-1:0] sysref_taps_in,
  // Register port
  input  wire [7:0]               reg_addr_in,
  input  wire [7:0]               reg_wdata_in,
  input  wire                     reg_wr_in,
  input  wire                     reg_rd_in,
  output reg  [7:0]               reg_rdata_out,
  // Delay line control
  output reg                      fine_step_out,
  // Capture results
  output reg                      sysref_capture_out,
  output reg                      lmfc_reset_out,
  output reg  [CNT_WIDTH-1:0]     lmfc_count_out,
  output reg                      link_64b66b_out
);

  // Control state
  reg  [PICK_WIDTH-1:0]    sample_pick_q;
  reg  [PICK_WIDTH-1:0]    sample_pick_d;
  reg                      fine_step_q;
  reg                      link_64b_q;
  reg  [CNT_WIDTH-1:0]     lmfc_period_q;
  reg                      map_clear_q;
  reg  [15:0]              window_cnt_q;
  reg                      map_valid_q;
  reg                      captured_seen_q;
  reg                      sample_prev_q;
  reg  [CNT_WIDTH-1:0]     lmfc_cnt_q;
  reg  [CNT_WIDTH-1:0]     lmfc_cnt_d;
  reg  [7:0]               rdata_d;
  wire [MAP_POSITIONS-1:0] risk_raw;
  wire [MAP_POSITIONS-1:0] phase_map;
  wire                     sample_now;
  wire                     sysref_edge;
  wire                     wr_ctrl;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == `OFS_SAMPLE_CTRL);

  // One edge detector per tap; the last tap has no neighbour and is forced
  genvar g;
  generate
    for (g = 0; g < MAP_POSITIONS - 1; g = g + 1) begin : g_tap
      sysref_tap_sampler u_tap (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .tap_in      (sysref_taps_in[g]),
        .next_tap_in (sysref_taps_in[g+1]),
        .clear_in    (map_clear_q),
        .risk_out    (risk_raw[g])
      ); // RULE_03
    end
  endgenerate
  assign risk_raw[MAP_POSITIONS-1] = 1'b0;

  // End positions lack margin information, so they always read risky
  assign phase_map = risk_raw | `PHASE_MAP_EDGE_BITS; // RULE_04 RULE_05

  // Capture mux reaches only the low sixteen taps
  sysref_pick_mux #(
    .PICK_POSITIONS (PICK_POSITIONS),
    .PICK_WIDTH     (PICK_WIDTH)
  ) u_pick (
    .taps_in    (sysref_taps_in[PICK_POSITIONS-1:0]),
    .pick_in    (sample_pick_q),
    .sample_out (sample_now)
  ); // RULE_06 RULE_07 RULE_08

  // Rising SYSREF at the chosen tap, on a fixed device clock edge
  assign sysref_edge = sample_now && !sample_prev_q; // RULE_01 RULE_02

  // Next pick value from the control write; only four bits exist
  always @* begin
    sample_pick_d = sample_pick_q;
    if (wr_ctrl) begin
      sample_pick_d = reg_wdata_in[`SAMPLE_PICK_MSB:`SAMPLE_PICK_LSB]; // RULE_15
    end
  end

  // Control registers
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sample_pick_q <= {PICK_WIDTH{1'b0}};
      fine_step_q   <= 1'b1;
      link_64b_q    <= 1'b0;
      map_clear_q   <= 1'b0;
      lmfc_period_q <= `LMFC_PERIOD_RESET;
    end else begin
      sample_pick_q <= sample_pick_d;
      map_clear_q   <= 1'b0;
      if (wr_ctrl) begin
        fine_step_q <= reg_wdata_in[`FINE_STEP_BIT]; // RULE_09
        link_64b_q  <= reg_wdata_in[`LINK_64B66B_BIT];
        map_clear_q <= reg_wdata_in[`MAP_CLEAR_BIT] | (fine_step_q != reg_wdata_in[`FINE_STEP_BIT]);
      end
      if (reg_wr_in && (reg_addr_in == `OFS_LMFC_CTRL)) begin
        lmfc_period_q <= reg_wdata_in[CNT_WIDTH-1:0];
      end
    end
  end

  // Map settles after a window of clocks; a step change restarts it
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || map_clear_q) begin
      window_cnt_q <= 16'h0000;
      map_valid_q  <= 1'b0;
    end else if (window_cnt_q != `MAP_WINDOW_CYCLES) begin
      window_cnt_q <= window_cnt_q + 16'h0001;
    end else begin
      map_valid_q  <= 1'b1;
    end
  end

  // Capture tracking; set beats a read clear of the seen flag
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sample_prev_q   <= 1'b0;
      captured_seen_q <= 1'b0;
    end else begin
      sample_prev_q <= sample_now;
      if (sysref_edge) begin
        captured_seen_q <= 1'b1;
      end else if (reg_rd_in && (reg_addr_in == `OFS_CAPTURE_STATUS)) begin
        captured_seen_q <= 1'b0;
      end
    end
  end

  // Local multiframe / extended multiblock counter, reset by SYSREF
  always @* begin
    if (sysref_edge) begin
      lmfc_cnt_d = {CNT_WIDTH{1'b0}}; // RULE_14
    end else if (lmfc_cnt_q == lmfc_period_q) begin
      lmfc_cnt_d = {CNT_WIDTH{1'b0}};
    end else begin
      lmfc_cnt_d = lmfc_cnt_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      lmfc_cnt_q <= {CNT_WIDTH{1'b0}};
    end else begin
      lmfc_cnt_q <= lmfc_cnt_d;
    end
  end

  // Read decode; unmapped addresses read zero
  always @* begin
    case (reg_addr_in)
      `OFS_PHASE_STATUS_LOW:  rdata_d = phase_map[7:0];
      `OFS_PHASE_STATUS_MID:  rdata_d = phase_map[15:8];
      `OFS_PHASE_STATUS_HIGH: rdata_d = phase_map[23:16];
      `OFS_SAMPLE_CTRL:       rdata_d = {2'b00, link_64b_q, fine_step_q, sample_pick_q};
      `OFS_CAPTURE_STATUS:    rdata_d = {6'h00, map_valid_q, captured_seen_q};
      `OFS_LMFC_CTRL:         rdata_d = lmfc_period_q;
      default:                rdata_d = 8'h00;
    endcase
  end

  // Registered outputs
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out      <= 8'h00;
      fine_step_out      <= 1'b1;
      sysref_capture_out <= 1'b0;
      lmfc_reset_out     <= 1'b0;
      lmfc_count_out     <= {CNT_WIDTH{1'b0}};
      link_64b66b_out    <= 1'b0;
    end else begin
      reg_rdata_out      <= reg_rd_in ? rdata_d : 8'h00;
      fine_step_out      <= fine_step_q; // RULE_09
      sysref_capture_out <= sample_now;
      lmfc_reset_out     <= sysref_edge; // RULE_14
      lmfc_count_out     <= lmfc_cnt_q;
      link_64b66b_out    <= link_64b_q;
    end
  end

endmodule

`default_nettype wire

//--- rtl/sysref_window_map.vh
/*
 * Register offsets, field positions, reset values and counts for the
 * SYSREF capture and windowing block. Included by the top design file, the checker and the bench.
 * Assumes nothing beyond a Verilog-2005 preprocessor.
 */
`ifndef SYSREF_WINDOW_MAP_VH
`define SYSREF_WINDOW_MAP_VH

// Phase map status registers, read only
`define OFS_PHASE_STATUS_LOW   8'h2C
`define OFS_PHASE_STATUS_MID   8'h2D
`define OFS_PHASE_STATUS_HIGH  8'h2E
// Control registers placed in free space
`define OFS_SAMPLE_CTRL        8'h30
`define OFS_CAPTURE_STATUS     8'h31
`define OFS_LMFC_CTRL          8'h32

// Sample control field layout
`define SAMPLE_PICK_LSB        0
`define SAMPLE_PICK_MSB        3
`define FINE_STEP_BIT          4
`define LINK_64B66B_BIT        5
`define MAP_CLEAR_BIT          6

// Reset values
`define SAMPLE_CTRL_RESET      8'h10
`define LMFC_PERIOD_RESET      8'h1F
`define PHASE_MAP_EDGE_BITS    24'h800001

// Map geometry
`define MAP_POSITIONS          24
`define PICK_POSITIONS         16
`define PICK_WIDTH             4

// Map accumulation window, in device clock cycles
`define MAP_WINDOW_CYCLES      16'h0100

`endif

//--- rtl/sysref_tap_sampler.v
/*
 * One candidate sampling position: samples SYSREF at a delayed clock tap
 * and compares it with its neighbour to flag an edge near this tap.
 * Assumes tap inputs are already in the device clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

module sysref_tap_sampler (
  // Clock and reset
  input  wire ref_clk_in,
  input  wire rst_n_in,
  // Tap samples
  input  wire tap_in,
  input  wire next_tap_in,
  input  wire clear_in,
  // Violation flag
  output reg  risk_out
);

  // Sticky: any disagreement with the neighbour means an edge lands here
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_in) begin
      risk_out <= 1'b0;
    end else if (tap_in != next_tap_in) begin
      risk_out <= 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- rtl/sysref_pick_mux.v
/*
 * Picks one of the first sixteen tap samples as the capture point.
 * Assumes taps are registered in the device clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

module sysref_pick_mux #(
  parameter PICK_POSITIONS = 16,
  parameter PICK_WIDTH     = 4
) (
  // Tap vector and choice
  input  wire [PICK_POSITIONS-1:0] taps_in,
  input  wire [PICK_WIDTH-1:0]     pick_in,
  // Selected sample
  output wire                      sample_out
);

  // Four-bit index cannot reach positions above fifteen
  assign sample_out = taps_in[pick_in];

endmodule

`default_nettype wire

//--- verif/sysref_capture_chk.sv
/* Port checker for the SYSREF capture block.
   Assumes a bind from the bench top. */
`timescale 1ns/10ps
`default_nettype none
`include "sysref_window_map.vh"
module sysref_capture_chk #(
  parameter MAP_POSITIONS = 24,
  parameter CNT_WIDTH     = 8
) (
  // Watched ports
  input wire logic                     ref_clk_in,
  input wire logic                     rst_n_in,
  input wire logic [MAP_POSITIONS-1:0] sysref_taps_in,
  input wire logic [7:0]               reg_addr_in,
  input wire logic                     reg_wr_in,
  input wire logic                     reg_rd_in,
  input wire logic [7:0]               reg_rdata_out,
  input wire logic                     fine_step_out,
  input wire logic                     sysref_capture_out,
  input wire logic                     lmfc_reset_out,
  input wire logic [CNT_WIDTH-1:0]     lmfc_count_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Capture rise, then counter restart within two cycles
  sequence s_cap_rise;
    $rose(sysref_capture_out);
  endsequence
  sequence s_restart;
    ##[0:2] lmfc_reset_out;
  endsequence
  AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data off slot");
  AST_MAP_LOW_EDGE: assert property (reg_rd_in && reg_addr_in == `OFS_PHASE_STATUS_LOW |=> reg_rdata_out[0])
    else $error("map bit 0 clear");
  AST_MAP_HIGH_EDGE: assert property (reg_rd_in && reg_addr_in == `OFS_PHASE_STATUS_HIGH |=> reg_rdata_out[7])
    else $error("map bit 23 clear");
  AST_RESET_VAL: assert property (disable iff (1'b0) !rst_n_in |=> fine_step_out && !lmfc_reset_out)
    else $error("reset values wrong");
  AST_TOP_TAPS: assert property (sysref_taps_in[15:0] == 16'h0000 |=> !sysref_capture_out)
    else $error("capture from upper tap");
  AST_CAP_RESTART: assert property (s_cap_rise |-> s_restart)
    else $error("no counter restart");
  AST_FINE_BY_WRITE: assert property ($changed(fine_step_out) |-> $past(reg_wr_in, 2)
    && $past(reg_addr_in, 2) == `OFS_SAMPLE_CTRL)
    else $error("step mode changed alone");
  AST_CNT_STEP: assert property (lmfc_count_out != $past(lmfc_count_out) + 1'b1 |-> lmfc_count_out == 0)
    else $error("counter jumped");
endmodule
`default_nettype wire

//--- verif/sysref_clock_source.sv
/* Clock-source model: plays one SYSREF pulse onto the tap bus.
   Assumes fire_in is a one-cycle request from the bench. */
`timescale 1ns/10ps
`default_nettype none
module sysref_clock_source (
  // Clock and pulse request
  input  wire logic       ref_clk_in,
  input  wire logic [4:0] step_pos_in,
  input  wire logic       fire_in,
  // Tap samples
  output var logic [23:0] taps_out
);
  logic [3:0]  phase_q = 4'h0;
  wire  [23:0] early_mask = (24'h000001 << step_pos_in) - 24'h000001;
  initial taps_out = 24'h000000;
  // Single pulse, fixed edge each time; low taps see each transition first
  always @(posedge ref_clk_in) begin
    phase_q <= (phase_q == 4'h0) ? {3'h0, fire_in} : ((phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1);
    if (phase_q == 4'h1)
      taps_out <= early_mask;
    else if (phase_q > 4'h1 && phase_q < 4'h8)
      taps_out <= 24'hFFFFFF;
    else if (phase_q == 4'h8)
      taps_out <= ~early_mask;
    else
      taps_out <= 24'h000000;
  end
endmodule
`default_nettype wire

//--- verif/sysref_capture_windowing_tb.sv
/* Bench for the SYSREF capture block: registers, map, capture, counter.
   Assumes design, source model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "sysref_window_map.vh"
module sysref_capture_windowing_tb;
  logic        clk, rst_n, wr, rd, fire, fine, cap, lrst, l64;
  logic [7:0]  addr, wdata, rdata, cnt, mx;
  logic [23:0] taps;
  int          errors, check_count, n;
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  sysref_capture_windowing dut (.ref_clk_in(clk), .rst_n_in(rst_n), .sysref_taps_in(taps),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .fine_step_out(fine), .sysref_capture_out(cap), .lmfc_reset_out(lrst), .lmfc_count_out(cnt),
    .link_64b66b_out(l64));
  sysref_clock_source src (.ref_clk_in(clk), .step_pos_in(5'h0A), .fire_in(fire), .taps_out(taps));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle bus strobes
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Send a pulse and wait, bounded, for the counter restart
  task automatic fire_wait;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    for (n = 0; n < 40 && lrst !== 1'b1; n++) @(posedge clk) #1;
    chk({7'h00, lrst}, 8'h01);
    chk({7'h00, cap}, 8'h01);
  endtask
  // Mid-run reset, then software reloads its stored pick
  task automatic t_repower;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({6'h00, l64, fine}, 8'h01);
    rd_reg(`OFS_SAMPLE_CTRL, 8'h10);
    wr_reg(`OFS_SAMPLE_CTRL, 8'h15);
    rd_reg(`OFS_SAMPLE_CTRL, 8'h15);
  endtask
  task automatic t_reset;
    rd_reg(`OFS_SAMPLE_CTRL, 8'h10);
    rd_reg(`OFS_LMFC_CTRL, 8'h1F);
    rd_reg(8'h7F, 8'h00);
  endtask
  task automatic t_map_capture;
    wr_reg(`OFS_SAMPLE_CTRL, 8'h55);
    fire_wait();
    repeat (260) @(posedge clk);
    rd_reg(`OFS_PHASE_STATUS_LOW, 8'h01);
    rd_reg(`OFS_PHASE_STATUS_MID, 8'h02);
    rd_reg(`OFS_PHASE_STATUS_HIGH, 8'h80);
    rd_reg(`OFS_CAPTURE_STATUS, 8'h03);
    rd_reg(`OFS_CAPTURE_STATUS, 8'h02);
    rd_reg(`OFS_SAMPLE_CTRL, 8'h15);
  endtask
  task automatic t_step_and_period;
    wr_reg(`OFS_PHASE_STATUS_LOW, 8'hFE);
    rd_reg(`OFS_PHASE_STATUS_LOW, 8'h01);
    wr_reg(`OFS_SAMPLE_CTRL, 8'h25);
    @(posedge clk) #1;
    chk({6'h00, l64, fine}, 8'h02);
    rd_reg(`OFS_PHASE_STATUS_MID, 8'h00);
    wr_reg(`OFS_LMFC_CTRL, 8'h03);
    fire_wait();
    mx = 8'h00;
    repeat (20) begin
      @(posedge clk) #1;
      if (cnt > mx) mx = cnt;
    end
    chk(mx, 8'h03);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    fire = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    errors = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_map_capture();
    t_step_and_period();
    t_repower();
    finish_test();
  end
  // Watchdog well past the expected run
  initial begin
    #500000;
    errors++;
    finish_test();
  end
endmodule
bind sysref_capture_windowing sysref_capture_chk #(.MAP_POSITIONS(MAP_POSITIONS), .CNT_WIDTH(CNT_WIDTH)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sysref_taps_in(sysref_taps_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .fine_step_out(fine_step_out),
  .sysref_capture_out(sysref_capture_out), .lmfc_reset_out(lmfc_reset_out), .lmfc_count_out(lmfc_count_out));
`default_nettype wire
